/* hw/ddma_regs.svh */
`ifndef DDMA_REGS_SVH
`define DDMA_REGS_SVH

// transfer, count and register bus widths
`define DDMA_AW        24
`define DDMA_CW        24
`define DDMA_DW        32
`define DDMA_RAW       8

// register byte offsets
`define DDMA_OFF_GO0   8'h00
`define DDMA_OFF_SRC0  8'h04
`define DDMA_OFF_DST0  8'h08
`define DDMA_OFF_CNT0  8'h0c
`define DDMA_OFF_GO1   8'h10
`define DDMA_OFF_SRC1  8'h14
`define DDMA_OFF_DST1  8'h18
`define DDMA_OFF_CNT1  8'h1c
`define DDMA_OFF_GCTRL 8'h20
`define DDMA_OFF_STAT  8'h24
`define DDMA_OFF_MASK  8'h28

// global control fields
`define DDMA_GC_W      7
`define DDMA_GC_RST    7'h00
`define DDMA_GC_PRIO   5:4
`define DDMA_GC_CROT   6

// axi responses
`define DDMA_RESP_OK   2'b00
`define DDMA_RESP_ERR  2'b10

`endif

/* hw/ddma_pkg.sv */
`include "ddma_regs.svh"

package ddma_pkg;

  typedef enum logic [1:0] {
    DDMA_PRIO_CPU = 2'b00,
    DDMA_PRIO_DMA = 2'b01,
    DDMA_PRIO_ROT = 2'b10,
    DDMA_PRIO_RSV = 2'b11
  } ddma_prio_e;

  typedef enum logic [1:0] {
    DDMA_IDLE  = 2'b00,
    DDMA_READ  = 2'b01,
    DDMA_WRITE = 2'b10
  } ddma_state_e;

  typedef enum logic [3:0] {
    DDMA_R_GO0   = 4'b0000,
    DDMA_R_SRC0  = 4'b0001,
    DDMA_R_DST0  = 4'b0010,
    DDMA_R_CNT0  = 4'b0011,
    DDMA_R_GO1   = 4'b0100,
    DDMA_R_SRC1  = 4'b0101,
    DDMA_R_DST1  = 4'b0110,
    DDMA_R_CNT1  = 4'b0111,
    DDMA_R_GCTRL = 4'b1000,
    DDMA_R_STAT  = 4'b1001,
    DDMA_R_MASK  = 4'b1010,
    DDMA_R_NONE  = 4'b1111
  } ddma_reg_e;

  typedef struct packed {
    logic                 we;
    logic [`DDMA_AW-1:0]  addr;
    logic [`DDMA_DW-1:0]  data;
  } ddma_acc_s;

  typedef struct packed {
    logic                 go;
    logic                 src_we;
    logic                 dst_we;
    logic                 cnt_we;
    logic [`DDMA_DW-1:0]  data;
  } ddma_load_s;

endpackage : ddma_pkg

/* hw/ddma_arb.sv */
`timescale 1ns/1ps
`default_nettype none

module ddma_arb (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire ddma_pkg::ddma_prio_e mode,
  input  wire logic              first_req,
  input  wire logic              second_req,
  input  wire logic              take,
  output logic                   second_win
);
  import ddma_pkg::*;

  logic turn_reg;
  logic turn_next;

  always_comb begin
    case (mode)
      DDMA_PRIO_DMA: second_win = second_req;
      DDMA_PRIO_ROT: second_win = second_req && (!first_req || turn_reg);
      default:       second_win = second_req && !first_req;
    endcase
    // first requester owns first grant, turn flips per settled conflict
    turn_next = turn_reg;
    if (take && first_req && second_req && mode == DDMA_PRIO_ROT) begin
      turn_next = !turn_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      turn_reg <= 1'b0;
    end else begin
      turn_reg <= turn_next;
    end
  end

endmodule : ddma_arb

`default_nettype wire

/* hw/ddma_chan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddma_regs.svh"

module ddma_chan (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire ddma_pkg::ddma_load_s load,
  input  wire logic               src_dec,
  input  wire logic               dst_dec,
  input  wire logic               acc_done,
  input  wire logic [`DDMA_DW-1:0] rdata,
  output logic                    req_valid,
  output ddma_pkg::ddma_acc_s     req,
  output logic                    busy,
  output logic                    done,
  output logic [`DDMA_AW-1:0]     src,
  output logic [`DDMA_AW-1:0]     dst,
  output logic [`DDMA_CW-1:0]     cnt
);
  import ddma_pkg::*;

  ddma_state_e         state_reg, state_next;
  logic [`DDMA_AW-1:0] src_reg, src_next, dst_reg, dst_next;
  logic [`DDMA_CW-1:0] cnt_reg, cnt_next;
  logic [`DDMA_DW-1:0] data_reg, data_next;
  logic                done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    src_next   = src_reg;
    dst_next   = dst_reg;
    cnt_next   = cnt_reg;
    data_next  = data_reg;
    done_next  = 1'b0;
    case (state_reg)
      DDMA_IDLE: begin
        // setup only while idle; running pointers are not disturbed
        if (load.src_we) src_next = load.data[`DDMA_AW-1:0];
        if (load.dst_we) dst_next = load.data[`DDMA_AW-1:0];
        if (load.cnt_we) cnt_next = load.data[`DDMA_CW-1:0];
        if (load.go) begin
          if (cnt_reg == '0) done_next = 1'b1;
          else state_next = DDMA_READ;
        end
      end
      DDMA_READ: begin
        if (acc_done) begin
          data_next  = rdata;
          state_next = DDMA_WRITE;
        end
      end
      DDMA_WRITE: begin
        if (acc_done) begin
          src_next = src_dec ? src_reg - 1'b1 : src_reg + 1'b1;
          dst_next = dst_dec ? dst_reg - 1'b1 : dst_reg + 1'b1;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == `DDMA_CW'(1)) begin
            state_next = DDMA_IDLE;
            done_next  = 1'b1;
          end else begin
            state_next = DDMA_READ;
          end
        end
      end
      default: state_next = DDMA_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= DDMA_IDLE;
      src_reg   <= '0;
      dst_reg   <= '0;
      cnt_reg   <= '0;
      data_reg  <= '0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg   <= src_next;
      dst_reg   <= dst_next;
      cnt_reg   <= cnt_next;
      data_reg  <= data_next;
      done_reg  <= done_next;
    end
  end

  // read the word from source, then write the held word to destination
  assign req_valid = (state_reg == DDMA_READ) || (state_reg == DDMA_WRITE);
  assign req.we    = (state_reg == DDMA_WRITE);
  assign req.addr  = (state_reg == DDMA_WRITE) ? dst_reg : src_reg;
  assign req.data  = data_reg;
  assign busy      = req_valid;
  assign done      = done_reg;
  assign src       = src_reg;
  assign dst       = dst_reg;
  assign cnt       = cnt_reg;

endmodule : ddma_chan

`default_nettype wire

/* hw/ddma_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddma_regs.svh"

module ddma_top #(
  parameter int NUM_CH = 2
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [`DDMA_RAW-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [`DDMA_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`DDMA_RAW-1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [`DDMA_DW-1:0]       s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      mem_req,
  output ddma_pkg::ddma_acc_s       mem_acc,
  input  wire logic [`DDMA_DW-1:0]  mem_rdata,
  input  wire logic                 mem_ack,
  input  wire logic                 cpu_req,
  output logic                      cpu_stall,
  output logic                      irq
);
  import ddma_pkg::*;

  function automatic ddma_reg_e decode(input logic [`DDMA_RAW-1:0] a);
    ddma_reg_e r;
    case (a)
      `DDMA_OFF_GO0:   r = DDMA_R_GO0;
      `DDMA_OFF_SRC0:  r = DDMA_R_SRC0;
      `DDMA_OFF_DST0:  r = DDMA_R_DST0;
      `DDMA_OFF_CNT0:  r = DDMA_R_CNT0;
      `DDMA_OFF_GO1:   r = DDMA_R_GO1;
      `DDMA_OFF_SRC1:  r = DDMA_R_SRC1;
      `DDMA_OFF_DST1:  r = DDMA_R_DST1;
      `DDMA_OFF_CNT1:  r = DDMA_R_CNT1;
      `DDMA_OFF_GCTRL: r = DDMA_R_GCTRL;
      `DDMA_OFF_STAT:  r = DDMA_R_STAT;
      `DDMA_OFF_MASK:  r = DDMA_R_MASK;
      default:         r = DDMA_R_NONE;
    endcase
    // second channel block is a hole on the single-channel build
    if (NUM_CH < 2 && r[3:2] == 2'b01) r = DDMA_R_NONE;
    return r;
  endfunction : decode

  function automatic logic [`DDMA_DW-1:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  // per-channel wiring
  ddma_load_s          load      [2];
  ddma_acc_s           chan_req  [2];
  logic [1:0]          chan_want;
  logic [1:0]          chan_busy;
  logic [1:0]          chan_done;
  logic [1:0]          acc_done;
  logic [`DDMA_AW-1:0] chan_src  [2];
  logic [`DDMA_AW-1:0] chan_dst  [2];
  logic [`DDMA_CW-1:0] chan_cnt  [2];

  // register file state
  logic                  aw_full_reg, aw_full_next;
  logic [`DDMA_RAW-1:0]  aw_addr_reg, aw_addr_next;
  logic                  w_full_reg, w_full_next;
  logic [`DDMA_DW-1:0]   w_data_reg, w_data_next;
  logic [3:0]            w_strb_reg, w_strb_next;
  logic                  bvalid_reg, bvalid_next;
  logic [1:0]            bresp_reg, bresp_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg, rvalid_next;
  logic [`DDMA_DW-1:0]   rdata_reg, rdata_next;
  logic [1:0]            rresp_reg, rresp_next;
  logic [`DDMA_GC_W-1:0] gctrl_reg, gctrl_next;
  logic [1:0]            stat_reg, stat_next;
  logic [1:0]            mask_reg, mask_next;
  logic                  irq_reg, irq_next;
  logic                  awready_reg, wready_reg;

  // transfer bus state
  logic      mem_req_reg, mem_req_next;
  ddma_acc_s mem_acc_reg, mem_acc_next;
  logic      owner_reg, owner_next;
  logic      stall_reg, stall_next;

  logic       wr_fire;
  ddma_reg_e  wsel;
  ddma_reg_e  rsel;
  logic [`DDMA_DW-1:0] lm;
  logic [`DDMA_DW-1:0] wmask;
  logic [`DDMA_DW-1:0] cur;
  logic       bus_idle;
  logic       any_want;
  logic       pick;
  logic       dma_win;
  logic       launch;
  ddma_prio_e bus_mode;
  ddma_prio_e chan_mode;

  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wsel    = decode(aw_addr_reg);
  assign lm      = lanes(w_strb_reg);
  assign wmask   = w_data_reg & lm;
  assign cur     = (wsel[1:0] == 2'b01) ? 32'(chan_src[wsel[2]]) :
                   (wsel[1:0] == 2'b10) ? 32'(chan_dst[wsel[2]]) : 32'(chan_cnt[wsel[2]]);

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      assign load[c].go     = wr_fire && wsel == ddma_reg_e'({1'b0, c[0], 2'b00}) && wmask[0];
      assign load[c].src_we = wr_fire && wsel == ddma_reg_e'({1'b0, c[0], 2'b01});
      assign load[c].dst_we = wr_fire && wsel == ddma_reg_e'({1'b0, c[0], 2'b10});
      assign load[c].cnt_we = wr_fire && wsel == ddma_reg_e'({1'b0, c[0], 2'b11});
      assign load[c].data   = wmask | (cur & ~lm);
      assign acc_done[c]    = mem_req_reg && mem_ack && owner_reg == c[0];
      if (c < NUM_CH) begin : g_on
        ddma_chan u_chan (
          .clk       (clk),
          .reset     (reset),
          .load      (load[c]),
          .src_dec   (gctrl_reg[2*c]),
          .dst_dec   (gctrl_reg[2*c+1]),
          .acc_done  (acc_done[c]),
          .rdata     (mem_rdata),
          .req_valid (chan_want[c]),
          .req       (chan_req[c]),
          .busy      (chan_busy[c]),
          .done      (chan_done[c]),
          .src       (chan_src[c]),
          .dst       (chan_dst[c]),
          .cnt       (chan_cnt[c])
        );
      end else begin : g_off
        assign chan_want[c] = 1'b0;
        assign chan_req[c]  = '0;
        assign chan_busy[c] = 1'b0;
        assign chan_done[c] = 1'b0;
        assign chan_src[c]  = '0;
        assign chan_dst[c]  = '0;
        assign chan_cnt[c]  = '0;
      end
    end
  endgenerate
  assign bus_mode  = (NUM_CH < 2) ? DDMA_PRIO_CPU : ddma_prio_e'(gctrl_reg[`DDMA_GC_PRIO]);
  assign chan_mode = gctrl_reg[`DDMA_GC_CROT] ? DDMA_PRIO_ROT : DDMA_PRIO_CPU;
  assign bus_idle  = !mem_req_reg;
  assign any_want  = |chan_want;
  assign launch    = bus_idle && any_want && dma_win;

  ddma_arb u_chan_arb (
    .clk        (clk),
    .reset      (reset),
    .mode       (chan_mode),
    .first_req  (chan_want[0]),
    .second_req (chan_want[1]),
    .take       (launch),
    .second_win (pick)
  );

  // cpu against dma on the shared resource
  ddma_arb u_bus_arb (
    .clk        (clk),
    .reset      (reset),
    .mode       (bus_mode),
    .first_req  (cpu_req),
    .second_req (bus_idle && any_want),
    .take       (bus_idle),
    .second_win (dma_win)
  );

  // transfer bus: one dma word in flight, apart from cpu buses
  always_comb begin
    mem_req_next = mem_req_reg;
    mem_acc_next = mem_acc_reg;
    owner_next   = owner_reg;
    // request waits on cpu_req in cpu and reserved priority modes, and in all modes when NUM_CH < 2; else dma mode never waits, rotate alternates
    if (launch) begin
      // dedicated dma port, one word per access
      mem_req_next = 1'b1;
      mem_acc_next = chan_req[pick];
      owner_next   = pick;
    end else if (mem_req_reg && mem_ack) begin
      mem_req_next = 1'b0;
    end
    // cpu told to back off while the dma owns the bus
    stall_next = mem_req_next;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_req_reg <= 1'b0;
      mem_acc_reg <= '0;
      owner_reg   <= 1'b0;
      stall_reg   <= 1'b0;
    end else begin
      mem_req_reg <= mem_req_next;
      mem_acc_reg <= mem_acc_next;
      owner_reg   <= owner_next;
      stall_reg   <= stall_next;
    end
  end

  // register slave
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    gctrl_next   = gctrl_reg;
    mask_next    = mask_reg;
    stat_next    = stat_reg;
    rsel         = decode(s_axi_araddr);
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wsel == DDMA_R_NONE) ? `DDMA_RESP_ERR : `DDMA_RESP_OK;
      if (wsel == DDMA_R_GCTRL) begin
        gctrl_next = (wmask[`DDMA_GC_W-1:0]) | (gctrl_reg & ~lm[`DDMA_GC_W-1:0]);
      end
      if (wsel == DDMA_R_MASK) mask_next = wmask[1:0] | (mask_reg & ~lm[1:0]);
      if (wsel == DDMA_R_STAT) stat_next = stat_reg & ~wmask[1:0];
    end
    // completion sets sticky flag, set beats clear
    stat_next = stat_next | chan_done;
    irq_next  = |(stat_next & mask_next);
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = (rsel == DDMA_R_NONE) ? `DDMA_RESP_ERR : `DDMA_RESP_OK;
      case (rsel[3:2])
        2'b00, 2'b01: begin
          case (rsel[1:0])
            2'b00:   rdata_next = 32'(chan_busy[rsel[2]]);
            2'b01:   rdata_next = 32'(chan_src[rsel[2]]);
            2'b10:   rdata_next = 32'(chan_dst[rsel[2]]);
            default: rdata_next = 32'(chan_cnt[rsel[2]]);
          endcase
        end
        2'b10: begin
          case (rsel[1:0])
            2'b00:   rdata_next = 32'(gctrl_reg);
            2'b01:   rdata_next = 32'(stat_reg);
            2'b10:   rdata_next = 32'(mask_reg);
            default: rdata_next = '0;
          endcase
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DDMA_RESP_OK;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `DDMA_RESP_OK;
      gctrl_reg   <= `DDMA_GC_RST;
      stat_reg    <= '0;
      mask_reg    <= '0;
      irq_reg     <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      // first read accepted one edge after release
      arready_reg <= arready_next | !rvalid_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      gctrl_reg   <= gctrl_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      irq_reg     <= irq_next;
    end
  end

  // ready flags are registered so outputs come from flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= !aw_full_next && !(s_axi_awvalid && awready_reg);
      wready_reg  <= !w_full_next && !(s_axi_wvalid && wready_reg);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign mem_req       = mem_req_reg;
  assign mem_acc       = mem_acc_reg;
  assign cpu_stall     = stall_reg;
  assign irq           = irq_reg;

endmodule : ddma_top

`default_nettype wire

/* dv/ddma_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddma_regs.svh"
module ddma_mem_model (
  input  wire logic                clk,
  input  wire ddma_pkg::ddma_acc_s mem_acc,
  input  wire logic                mem_req,
  input  var  int                  mem_lat,
  output logic [`DDMA_DW-1:0]      mem_rdata,
  output logic                     mem_ack
);
  import ddma_pkg::*;
  logic [`DDMA_DW-1:0] mem [int];
  int                  wait_cnt = 0;
  initial begin
    mem_rdata = '0;
    mem_ack = 1'b0;
  end
  // one word per access, any address
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // inverted when idle so stale data never looks valid
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_cnt >= mem_lat) begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_acc.we) mem[mem_acc.addr] = mem_acc.data;
        else mem_rdata <= mem.exists(mem_acc.addr) ? mem[mem_acc.addr] : '0;
      end else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : ddma_mem_model
`default_nettype wire

/* dv/ddma_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddma_regs.svh"
module ddma_checker (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                mem_req,
  input wire ddma_pkg::ddma_acc_s mem_acc,
  input wire logic [`DDMA_DW-1:0] mem_rdata,
  input wire logic                mem_ack,
  input wire logic                cpu_stall,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready
);
  import ddma_pkg::*;
  logic                pend_reg, pend_next;
  logic [`DDMA_DW-1:0] word_reg, word_next;
  always_comb begin
    pend_next = pend_reg;
    word_next = word_reg;
    if (mem_req && mem_ack) begin
      pend_next = !mem_acc.we;
      word_next = mem_acc.we ? word_reg : mem_rdata;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      pend_reg <= pend_next;
      word_reg <= word_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_acc))
    else $error("dma access changed before ack");
  chk_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("no idle cycle after dma ack");
  chk_stall_match: assert property (cpu_stall == mem_req)
    else $error("cpu stall differs from dma request");
  chk_write_word: assert property (mem_req && mem_acc.we && pend_reg |-> mem_acc.data == word_reg)
    else $error("written word is not the word read");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stayed after bready");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
endmodule : ddma_checker
bind ddma_top ddma_checker u_chk (
  .clk, .reset, .mem_req, .mem_acc, .mem_rdata, .mem_ack, .cpu_stall, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

/* dv/ddma_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddma_regs.svh"
module testbench;
  import ddma_pkg::*;
  logic                 clk, reset, cpu_req, mem_req, mem_ack, irq, cpu_stall;
  logic [`DDMA_RAW-1:0] s_axi_awaddr, s_axi_araddr;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                 s_axi_rvalid, s_axi_rready;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [3:0]           s_axi_wstrb;
  logic [`DDMA_DW-1:0]  s_axi_wdata, s_axi_rdata, mem_rdata;
  ddma_acc_s            mem_acc;
  int                   error_cnt, n_compared, acc_cnt, mem_lat;
  ddma_top #(.NUM_CH(2)) i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_acc, .mem_rdata, .mem_ack, .cpu_req,
    .cpu_stall, .irq);
  ddma_mem_model i_mem (.clk, .mem_acc, .mem_req, .mem_lat, .mem_rdata, .mem_ack);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (mem_req && mem_ack) acc_cnt <= acc_cnt + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(`DDMA_OFF_GCTRL, v, r);
    chk(v, `DDMA_GC_RST);
    axi_rd(`DDMA_OFF_MASK, v, r);
    chk(v, 32'h0);
    axi_rd(8'h2c, v, r);
    chk({r, v[29:0]}, {`DDMA_RESP_ERR, 30'h0});
    axi_wr(8'h2c, 32'h1, r);
    chk(r, `DDMA_RESP_ERR);
    axi_wr(`DDMA_OFF_SRC1, 32'hff123456, r);
    axi_rd(`DDMA_OFF_SRC1, v, r);
    chk(v, 32'h00123456);
  endtask : t_regs
  task automatic t_copy(input int ch, input logic [23:0] s, input logic [23:0] d, input int n,
                        input logic [6:0] gc, input int lat);
    logic [31:0] v;
    logic [1:0]  r;
    logic [7:0]  b;
    int          sd, dd;
    b = ch ? 8'h10 : 8'h00;
    sd = gc[2*ch] ? -1 : 1;
    dd = gc[2*ch+1] ? -1 : 1;
    for (int k = 0; k < n; k++) i_mem.mem[int'(s) + k*sd] = 32'h5a000000 + k;
    mem_lat <= lat;
    acc_cnt = 0;
    axi_wr(`DDMA_OFF_GCTRL, {25'h0, gc}, r);
    axi_wr(`DDMA_OFF_SRC0 + b, {8'h0, s}, r);
    axi_wr(`DDMA_OFF_DST0 + b, {8'h0, d}, r);
    axi_wr(`DDMA_OFF_CNT0 + b, n, r);
    axi_wr(`DDMA_OFF_GO0 + b, 32'h1, r);
    do axi_rd(`DDMA_OFF_STAT, v, r); while (!v[ch]);
    for (int k = 0; k < n; k++) chk(i_mem.mem[int'(d) + k*dd], 32'h5a000000 + k);
    chk(acc_cnt, 2*n);
    axi_rd(`DDMA_OFF_SRC0 + b, v, r);
    chk(v, {8'h0, s + 24'(n*sd)});
    axi_rd(`DDMA_OFF_CNT0 + b, v, r);
    chk(v, 32'h0);
    axi_wr(`DDMA_OFF_STAT, 32'h1 << ch, r);
  endtask : t_copy
  task automatic t_irq();
    logic [31:0] v;
    logic [1:0]  r;
    acc_cnt = 0;
    axi_wr(`DDMA_OFF_MASK, 32'h1, r);
    axi_wr(`DDMA_OFF_CNT0, 32'h0, r);
    axi_wr(`DDMA_OFF_GO0, 32'h1, r);
    repeat (4) @(posedge clk);
    chk({irq, acc_cnt[0]}, 2'b10);
    axi_wr(`DDMA_OFF_STAT, 32'h1, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    axi_wr(`DDMA_OFF_MASK, 32'h0, r);
    axi_wr(`DDMA_OFF_GO0, 32'h1, r);
    repeat (4) @(posedge clk);
    axi_rd(`DDMA_OFF_STAT, v, r);
    chk({irq, v[0]}, 2'b01);
    axi_wr(`DDMA_OFF_STAT, 32'h1, r);
  endtask : t_irq
  task automatic t_prio();
    logic [31:0] v;
    logic [1:0]  r;
    for (int m = 0; m < 4; m++) begin
      cpu_req <= 1'b1;
      axi_wr(`DDMA_OFF_GCTRL, m << 4, r);
      axi_wr(`DDMA_OFF_CNT0, 32'h2, r);
      axi_wr(`DDMA_OFF_GO0, 32'h1, r);
      repeat (60) @(posedge clk);
      axi_rd(`DDMA_OFF_STAT, v, r);
      chk(v[0], m == 1 || m == 2);
      cpu_req <= 1'b0;
      do axi_rd(`DDMA_OFF_STAT, v, r); while (!v[0]);
      axi_wr(`DDMA_OFF_STAT, 32'h1, r);
    end
  endtask : t_prio
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    {reset, cpu_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b10000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hf};
    {mem_lat, acc_cnt, error_cnt, n_compared} = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    // dest high in the address space, fast memory
    t_copy(0, 24'h000100, 24'h808000, 3, 7'h00, 0);
    t_copy(1, 24'h000210, 24'h000330, 2, 7'h0c, 3);
    t_irq();
    t_prio();
    close_out();
  end
endmodule : testbench
`default_nettype wire
